/* File: rtl/mgmt_map_pkg.sv */
// Constants and carrier types for the indirect management register map
package mgmt_map_pkg;
	// ==========================================================
	// Command byte layout
	localparam logic [2:0] CMD_BANK_TAG = 3'h0;
	localparam logic [2:0] CMD_REG_TAG = 3'h7;
	localparam int CMD_TAG_MSB = 7;
	localparam int CMD_TAG_LSB = 5;
	localparam int SEL_W = 5;
	// ==========================================================
	// Bank numbers
	localparam logic [4:0] BANK_REPEATER = 5'h00;
	localparam logic [4:0] BANK_STATUS = 5'h01;
	localparam logic [4:0] BANK_CONTROL = 5'h02;
	localparam logic [4:0] BANK_TWISTED_FIRST = 5'h10;
	localparam logic [4:0] BANK_TWISTED_LAST = 5'h17;
	localparam logic [4:0] BANK_ATTACH = 5'h1f;
	localparam int NUM_PORTS = 9;
	localparam logic [3:0] ATTACH_INDEX = 4'h8;
	// ==========================================================
	// Register numbers in the repeater bank
	localparam logic [4:0] REG_SRCADDR_CMP = 5'h0a;
	localparam logic [4:0] REG_OCTETS = 5'h0c;
	localparam logic [4:0] REG_XMIT_COLL = 5'h0d;
	localparam logic [4:0] REG_CONFIG = 5'h10;
	localparam logic [4:0] REG_VERSION = 5'h1c;
	localparam logic [4:0] REG_MGMT_SET = 5'h1e;
	localparam logic [4:0] REG_MGMT_GET = 5'h1f;
	// Status and control banks
	localparam int NUM_FLAG_REGS = 10;
	localparam int NUM_IE_REGS = 8;
	localparam logic [4:0] REG_RESERVED_4 = 5'h04;
	localparam logic [4:0] REG_TP_SA_HIT = 5'h08;
	localparam logic [4:0] REG_AUI_SA_HIT = 5'h09;
	// Per-port bank
	localparam int NUM_COUNTERS = 13;
	localparam logic [4:0] REG_LAST_SRCADDR = 5'h0e;
	// ==========================================================
	// Transfer lengths in bytes
	localparam logic [2:0] LEN_1 = 3'h1;
	localparam logic [2:0] LEN_4 = 3'h4;
	localparam logic [2:0] LEN_6 = 3'h6;
	// Configuration bits and reset values
	localparam int CFG_IRQ_EN = 7;
	localparam int CFG_IFERR_IE = 6;
	localparam int CFG_SAHIT_IE = 5;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] IE_RESET = 8'h00;
	localparam logic [7:0] MGMT_GET_RESET = 8'h00;
	// ==========================================================
	// Host access, one cycle per byte
	typedef struct packed {
		logic rd;
		logic wr;
		logic cmd_sel;
		logic [7:0] wdata;
	} host_req_t;
	// Counter update from the statistics engine
	typedef struct packed {
		logic valid;
		logic [3:0] port;
		logic [3:0] idx;
		logic [31:0] value;
	} stat_upd_t;
	// Last source address update
	typedef struct packed {
		logic valid;
		logic [3:0] port;
		logic [47:0] addr;
	} srcaddr_upd_t;
endpackage

/* File: rtl/indirect_mgmt_register_map.sv */
// Indirect command/data port register map with byte sequencing
//
// Contract
// - Command byte 000xxxxx loads bank selector
// - Command byte 111xxxxx loads register selector
// - Banks: repeater, status, control, port attributes
// - Repeater bank register numbers as mapped
// - Repeater counters: four bytes, low first
// - Compare value: six bytes, read/write
// - Single-byte config, version, set, get
// - Status bank change flags, read only
// - Control bank interrupt enables, read/write
// - Port banks: counters, reserved, last address
// - Port counters four bytes, low first
// - Last source address six bytes, read/write
// - Attribute storage untouched by reset
// - Command port read returns status
// - Select high is command, low data
// - Holding copy on first byte, restart
// - Unwritten selectors keep previous value
`timescale 1ns/1ps
module indirect_mgmt_register_map #(
	parameter logic [7:0] VERSION_ID = 8'h01 // arbitrary value
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire mgmt_map_pkg::host_req_t host_req,
	input wire logic [31:0] repeater_octets,
	input wire logic [31:0] repeater_collisions,
	input wire mgmt_map_pkg::stat_upd_t stat_upd,
	input wire mgmt_map_pkg::srcaddr_upd_t srcaddr_upd,
	input wire logic [9:0][7:0] flag_set,
	input wire logic iface_error,
	input wire logic mgmt_get_load,
	input wire logic [7:0] mgmt_get_data,
	output logic [7:0] rd_data_reg,
	output logic rd_valid_reg,
	output logic irq_reg,
	output logic [7:0] mgmt_set_byte_reg,
	output logic mgmt_set_stb_reg
);
	// ==========================================================
	// Storage
	logic [4:0] bank_sel_reg;
	logic [4:0] reg_sel_reg;
	logic [2:0] seq_reg;
	logic [47:0] hold_reg;
	logic [39:0] wr_hold_reg;
	logic [7:0] config_reg;
	logic [7:0] mgmt_get_reg;
	logic iferr_reg;
	logic [9:0][7:0] flag_reg;
	logic [7:0][7:0] ie_reg;
	logic [47:0] sacmp_reg;
	logic [31:0] stat_mem [mgmt_map_pkg::NUM_PORTS][mgmt_map_pkg::NUM_COUNTERS];
	logic [47:0] lsa_mem [mgmt_map_pkg::NUM_PORTS];

	// ==========================================================
	// Access decode
	logic cmd_wr, cmd_rd, data_wr, data_rd;
	logic [2:0] cmd_tag;
	logic port_bank;
	logic [3:0] port_idx;
	logic [2:0] cur_len;
	logic [47:0] cur_val;
	logic multi;
	logic last_byte;
	logic sa_hit;
	logic [7:0] status_byte;

	// Select pin is the only address input
	assign cmd_wr = host_req.wr & host_req.cmd_sel;
	assign cmd_rd = host_req.rd & host_req.cmd_sel;
	assign data_wr = host_req.wr & ~host_req.cmd_sel;
	assign data_rd = host_req.rd & ~host_req.cmd_sel;
	assign cmd_tag = host_req.wdata[mgmt_map_pkg::CMD_TAG_MSB:
		mgmt_map_pkg::CMD_TAG_LSB];

	// Port banks map onto storage rows 0..8
	always_comb begin
		port_bank = 1'b0;
		port_idx = 4'h0;
		if (bank_sel_reg >= mgmt_map_pkg::BANK_TWISTED_FIRST &&
			bank_sel_reg <= mgmt_map_pkg::BANK_TWISTED_LAST) begin
			port_bank = 1'b1;
			port_idx = {1'b0, bank_sel_reg[2:0]};
		end else if (bank_sel_reg == mgmt_map_pkg::BANK_ATTACH) begin
			port_bank = 1'b1;
			port_idx = mgmt_map_pkg::ATTACH_INDEX;
		end
	end

	// Value and length of the selected register; unlisted reads zero
	always_comb begin
		cur_len = mgmt_map_pkg::LEN_1;
		cur_val = 48'h0;
		if (bank_sel_reg == mgmt_map_pkg::BANK_REPEATER) begin
			case (reg_sel_reg)
			mgmt_map_pkg::REG_SRCADDR_CMP: begin
				cur_len = mgmt_map_pkg::LEN_6;
				cur_val = sacmp_reg;
			end
			mgmt_map_pkg::REG_OCTETS: begin
				cur_len = mgmt_map_pkg::LEN_4;
				cur_val = {16'h0, repeater_octets};
			end
			mgmt_map_pkg::REG_XMIT_COLL: begin
				cur_len = mgmt_map_pkg::LEN_4;
				cur_val = {16'h0, repeater_collisions};
			end
			mgmt_map_pkg::REG_CONFIG: cur_val = {40'h0, config_reg};
			mgmt_map_pkg::REG_VERSION: cur_val = {40'h0, VERSION_ID};
			mgmt_map_pkg::REG_MGMT_GET: cur_val = {40'h0, mgmt_get_reg};
			default: cur_val = 48'h0;
			endcase
		end else if (bank_sel_reg == mgmt_map_pkg::BANK_STATUS) begin
			if (reg_sel_reg < 5'(mgmt_map_pkg::NUM_FLAG_REGS) &&
				reg_sel_reg != mgmt_map_pkg::REG_RESERVED_4)
				cur_val = {40'h0, flag_reg[reg_sel_reg[3:0]]};
		end else if (bank_sel_reg == mgmt_map_pkg::BANK_CONTROL) begin
			if (reg_sel_reg < 5'(mgmt_map_pkg::NUM_IE_REGS) &&
				reg_sel_reg != mgmt_map_pkg::REG_RESERVED_4)
				cur_val = {40'h0, ie_reg[reg_sel_reg[2:0]]};
		end else if (port_bank) begin
			if (reg_sel_reg < 5'(mgmt_map_pkg::NUM_COUNTERS)) begin
				cur_len = mgmt_map_pkg::LEN_4;
				cur_val = {16'h0, stat_mem[port_idx][reg_sel_reg[3:0]]};
			end else if (reg_sel_reg == mgmt_map_pkg::REG_LAST_SRCADDR) begin
				cur_len = mgmt_map_pkg::LEN_6;
				cur_val = lsa_mem[port_idx];
			end
		end
	end

	assign multi = (cur_len != mgmt_map_pkg::LEN_1);
	assign last_byte = (seq_reg == cur_len - 3'h1);
	assign sa_hit = (|flag_reg[mgmt_map_pkg::REG_TP_SA_HIT[3:0]]) |
		(|flag_reg[mgmt_map_pkg::REG_AUI_SA_HIT[3:0]]);
	assign status_byte = {irq_reg, iferr_reg, sa_hit, 5'h00};

	// ==========================================================
	// Selectors; other command tags are dropped
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bank_sel_reg <= 5'h00;
			reg_sel_reg <= 5'h00;
		end else if (clk_en && cmd_wr) begin
			if (cmd_tag == mgmt_map_pkg::CMD_BANK_TAG)
				bank_sel_reg <= host_req.wdata[4:0];
			else if (cmd_tag == mgmt_map_pkg::CMD_REG_TAG)
				reg_sel_reg <= host_req.wdata[4:0];
			// Neither tag: both kept, as for any untouched selector
		end
	end

	// ==========================================================
	// Byte sequencer: restarts on any command write
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			seq_reg <= 3'h0;
		end else if (clk_en) begin
			if (cmd_wr)
				seq_reg <= 3'h0;
			else if ((data_rd || data_wr) && multi)
				seq_reg <= last_byte ? 3'h0 : seq_reg + 3'h1;
		end
	end

	// Snapshot on the first byte so a live counter reads coherently
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hold_reg <= 48'h0;
			wr_hold_reg <= 40'h0;
		end else if (clk_en) begin
			if (data_rd && multi && seq_reg == 3'h0)
				hold_reg <= cur_val;
			if (data_wr && multi && !last_byte)
				wr_hold_reg[8*seq_reg +: 8] <= host_req.wdata;
		end
	end

	// ==========================================================
	// Read answer, one cycle after the request
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else if (clk_en) begin
			rd_valid_reg <= host_req.rd;
			if (cmd_rd)
				rd_data_reg <= status_byte;
			else if (data_rd && multi && seq_reg != 3'h0)
				rd_data_reg <= hold_reg[8*seq_reg +: 8];
			else if (data_rd)
				rd_data_reg <= cur_val[7:0];
		end
	end

	// ==========================================================
	// Single-byte writable registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			config_reg <= mgmt_map_pkg::CONFIG_RESET;
			mgmt_get_reg <= mgmt_map_pkg::MGMT_GET_RESET;
			ie_reg <= {8{mgmt_map_pkg::IE_RESET}};
			mgmt_set_byte_reg <= 8'h00;
			mgmt_set_stb_reg <= 1'b0;
		end else if (clk_en) begin
			mgmt_set_stb_reg <= 1'b0;
			if (mgmt_get_load)
				mgmt_get_reg <= mgmt_get_data;
			if (data_wr && bank_sel_reg == mgmt_map_pkg::BANK_REPEATER) begin
				case (reg_sel_reg)
				mgmt_map_pkg::REG_CONFIG: config_reg <= host_req.wdata;
				mgmt_map_pkg::REG_MGMT_SET: begin
					mgmt_set_byte_reg <= host_req.wdata;
					mgmt_set_stb_reg <= 1'b1;
				end
				mgmt_map_pkg::REG_MGMT_GET: mgmt_get_reg <= host_req.wdata;
				default: ;
				endcase
			end
			if (data_wr && bank_sel_reg == mgmt_map_pkg::BANK_CONTROL &&
				reg_sel_reg < 5'(mgmt_map_pkg::NUM_IE_REGS) &&
				reg_sel_reg != mgmt_map_pkg::REG_RESERVED_4)
				ie_reg[reg_sel_reg[2:0]] <= host_req.wdata;
		end
	end

	// ==========================================================
	// Sticky change flags, cleared by reading; a new event wins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flag_reg <= '0;
			iferr_reg <= 1'b0;
		end else if (clk_en) begin
			for (int i = 0; i < mgmt_map_pkg::NUM_FLAG_REGS; i++) begin
				if (data_rd && bank_sel_reg == mgmt_map_pkg::BANK_STATUS &&
					reg_sel_reg == 5'(i) && i != 4)
					flag_reg[i] <= flag_set[i];
				else if (i != 4)
					flag_reg[i] <= flag_reg[i] | flag_set[i];
			end
			iferr_reg <= (iferr_reg & ~cmd_rd) | iface_error;
		end
	end

	// Interrupt level: master enable gates all sources
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else if (clk_en) begin
			irq_reg <= config_reg[mgmt_map_pkg::CFG_IRQ_EN] &
				((|(flag_reg[7:0] & ie_reg)) |
				(config_reg[mgmt_map_pkg::CFG_IFERR_IE] & iferr_reg) |
				(config_reg[mgmt_map_pkg::CFG_SAHIT_IE] & sa_hit));
		end
	end

	// ==========================================================
	// Attribute storage: no reset, so it survives external reset
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			if (data_wr && last_byte && bank_sel_reg ==
				mgmt_map_pkg::BANK_REPEATER &&
				reg_sel_reg == mgmt_map_pkg::REG_SRCADDR_CMP)
				sacmp_reg <= {host_req.wdata, wr_hold_reg};
		end
	end

	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			if (data_wr && last_byte && port_bank &&
				reg_sel_reg == mgmt_map_pkg::REG_LAST_SRCADDR)
				lsa_mem[port_idx] <= {host_req.wdata, wr_hold_reg};
			// The engine's own update lands after a host write
			if (srcaddr_upd.valid &&
				srcaddr_upd.port < 4'(mgmt_map_pkg::NUM_PORTS))
				lsa_mem[srcaddr_upd.port] <= srcaddr_upd.addr;
			if (stat_upd.valid && stat_upd.port < 4'(mgmt_map_pkg::NUM_PORTS) &&
				stat_upd.idx < 4'(mgmt_map_pkg::NUM_COUNTERS))
				stat_mem[stat_upd.port][stat_upd.idx] <= stat_upd.value;
		end
	end

	// ==========================================================
	// Checks
	a_bank_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && cmd_wr && cmd_tag == 3'h0 |=>
		bank_sel_reg == $past(host_req.wdata[4:0]))
		else $error("bank selector not loaded");

	a_reg_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && cmd_wr && cmd_tag == 3'h7 |=>
		reg_sel_reg == $past(host_req.wdata[4:0]) && $stable(bank_sel_reg))
		else $error("register selector not loaded");

	a_cmd_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && cmd_wr && cmd_tag != 3'h0 && cmd_tag != 3'h7 |=>
		$stable(bank_sel_reg) && $stable(reg_sel_reg))
		else $error("bad command tag changed a selector");

	a_sel_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(clk_en && cmd_wr) |=> $stable(bank_sel_reg) && $stable(reg_sel_reg))
		else $error("selector changed without command write");

	a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && cmd_rd |=> rd_valid_reg &&
		rd_data_reg[7] == $past(irq_reg) && rd_data_reg[4:0] == 5'h00)
		else $error("status byte not returned");

	a_seq_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && cmd_wr |=> seq_reg == 3'h0)
		else $error("sequence not restarted by command write");

	a_single_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_rd && !multi && !cmd_wr |=> $stable(seq_reg))
		else $error("single-byte access advanced sequence");

	a_seq_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_rd && multi && last_byte && !cmd_wr |=> seq_reg == 3'h0)
		else $error("sequence did not wrap after last byte");

	a_count_lsb: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_rd && cur_len == 3'h4 && seq_reg == 3'h0 |=>
		rd_data_reg == $past(cur_val[7:0]) && seq_reg == 3'h1)
		else $error("counter read did not start at low byte");

	a_wide_commit: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_wr && last_byte &&
		bank_sel_reg == 5'h00 && reg_sel_reg == 5'h0a |=>
		sacmp_reg[47:40] == $past(host_req.wdata))
		else $error("six-byte write not committed");

	a_read_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> rd_valid_reg == $past(host_req.rd))
		else $error("read answer flag wrong");

	a_set_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_wr && bank_sel_reg == mgmt_map_pkg::BANK_REPEATER &&
		reg_sel_reg == mgmt_map_pkg::REG_MGMT_SET |=>
		mgmt_set_stb_reg && mgmt_set_byte_reg == $past(host_req.wdata))
		else $error("management set byte not sent");

	a_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_rd && bank_sel_reg == mgmt_map_pkg::BANK_STATUS &&
		reg_sel_reg == 5'h00 |=> flag_reg[0] == $past(flag_set[0]))
		else $error("status flag not cleared by read");

	a_ie_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_wr && bank_sel_reg == mgmt_map_pkg::BANK_CONTROL &&
		reg_sel_reg < 5'(mgmt_map_pkg::NUM_IE_REGS) &&
		reg_sel_reg != mgmt_map_pkg::REG_RESERVED_4 |=>
		ie_reg[$past(reg_sel_reg[2:0])] == $past(host_req.wdata))
		else $error("interrupt enable not written");

	a_snapshot: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_rd && multi && seq_reg == 3'h0 |=>
		hold_reg == $past(cur_val))
		else $error("holding copy not taken on first byte");

	a_irq_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !config_reg[mgmt_map_pkg::CFG_IRQ_EN] |=> !irq_reg)
		else $error("interrupt raised while masked");

	a_lsa_commit: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && data_wr && last_byte && port_bank && !srcaddr_upd.valid &&
		reg_sel_reg == mgmt_map_pkg::REG_LAST_SRCADDR |=>
		lsa_mem[$past(port_idx)][47:40] == $past(host_req.wdata))
		else $error("last source address not committed");

endmodule // indirect_mgmt_register_map

/* File: verification/host_bus_model.sv */
// Host processor model for the command/data byte bus
`timescale 1ns/1ps
module host_bus_model (
	input wire logic core_clk,
	input wire logic [7:0] rd_data_reg,
	input wire logic rd_valid_reg,
	output mgmt_map_pkg::host_req_t host_req
);
	logic [7:0] last_wdata;
	// ======================================================
	// Idle bus at time zero
	initial begin
		host_req = '0;
		last_wdata = 8'h00;
	end
	// One write; released data lines show the inverse byte
	task automatic put(input logic sel, input logic [7:0] b);
		@(posedge core_clk);
		host_req <= '{rd: 1'b0, wr: 1'b1, cmd_sel: sel, wdata: b};
		last_wdata = b;
		@(posedge core_clk);
		host_req <= '{rd: 1'b0, wr: 1'b0, cmd_sel: sel, wdata: ~b};
	endtask
	// One read; the answer is picked up just after the taking edge
	task automatic get(input logic sel, output logic [7:0] b,
		output logic ok);
		@(posedge core_clk);
		host_req <= '{rd: 1'b1, wr: 1'b0, cmd_sel: sel,
			wdata: ~last_wdata};
		@(posedge core_clk);
		host_req.rd <= 1'b0;
		#1;
		b = rd_data_reg;
		ok = rd_valid_reg;
	endtask
	// Bank then register selection
	task automatic sel_reg(input logic [4:0] p, input logic [4:0] r);
		put(1'b1, {mgmt_map_pkg::CMD_BANK_TAG, p});
		put(1'b1, {mgmt_map_pkg::CMD_REG_TAG, r});
	endtask
	// A six-byte value is always written whole, low byte first
	task automatic put6(input logic [47:0] v);
		for (int i = 0; i < 6; i++) begin
			put(1'b0, v[8*i +: 8]);
		end
	endtask
endmodule // host_bus_model

/* File: verification/tb_indirect_mgmt_register_map.sv */
// Self-checking bench for the indirect management register map
`timescale 1ns/1ps
module tb_indirect_mgmt_register_map;
	typedef struct {
		logic [4:0] bank;
		logic [4:0] num;
		logic [7:0] wr;
		logic [7:0] exp;
	} row_t;
	localparam logic [7:0] VER = 8'h01; // arbitrary value
	logic core_clk;
	logic rst_n;
	logic clk_en;
	mgmt_map_pkg::host_req_t host_req;
	logic [31:0] repeater_octets;
	logic [31:0] repeater_collisions;
	logic iface_error;
	mgmt_map_pkg::stat_upd_t stat_upd;
	logic [9:0][7:0] flag_set;
	logic mgmt_get_load;
	logic [7:0] mgmt_get_data;
	logic [7:0] rd_data_reg;
	logic rd_valid_reg;
	logic irq_reg;
	logic [7:0] mgmt_set_byte_reg;
	logic mgmt_set_stb_reg;
	logic [47:0] wide;
	int n_mismatch;
	int checked;
	row_t rows [7];
	// ======================================================
	// Design and host model
	indirect_mgmt_register_map #(.VERSION_ID(VER)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.host_req(host_req), .repeater_octets(repeater_octets),
		.repeater_collisions(repeater_collisions), .stat_upd(stat_upd),
		.srcaddr_upd('0), .flag_set(flag_set), .iface_error(iface_error),
		.mgmt_get_load(mgmt_get_load), .mgmt_get_data(mgmt_get_data),
		.rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
		.irq_reg(irq_reg), .mgmt_set_byte_reg(mgmt_set_byte_reg),
		.mgmt_set_stb_reg(mgmt_set_stb_reg));
	host_bus_model host_u (.core_clk(core_clk),
		.rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
		.host_req(host_req));
	// Clock at 125 MHz
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ======================================================
	// Compare, read and closing tasks
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic rd_exp(input logic sel, input logic [7:0] exp);
		logic [7:0] b;
		logic ok;
		host_u.get(sel, b, ok);
		check8({7'h00, ok}, 8'h01);
		check8(b, exp);
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
	// ======================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		repeater_octets = 32'h00000000;
		repeater_collisions = 32'h78563412;
		iface_error = 1'b0;
		stat_upd = '0;
		flag_set = '0;
		mgmt_get_load = 1'b0;
		mgmt_get_data = 8'h00;
		n_mismatch = 0;
		checked = 0;
		rows = '{'{5'h00, 5'h10, 8'h80, 8'h80}, '{5'h00, 5'h1f, 8'h5a, 8'h5a},
			'{5'h00, 5'h1c, 8'hff, VER}, '{5'h02, 5'h00, 8'h01, 8'h01},
			'{5'h02, 5'h07, 8'hc3, 8'hc3}, '{5'h01, 5'h01, 8'hff, 8'h00},
			'{5'h02, 5'h05, 8'h3c, 8'h3c}};
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		rd_exp(1'b1, 8'h00);
		// Interface error shows once in status, then clears
		@(posedge core_clk);
		iface_error <= 1'b1;
		@(posedge core_clk);
		iface_error <= 1'b0;
		rd_exp(1'b1, 8'h40);
		rd_exp(1'b1, 8'h00);
		// Single-byte registers: write, then read back
		foreach (rows[i]) begin
			host_u.sel_reg(rows[i].bank, rows[i].num);
			host_u.put(1'b0, rows[i].wr);
			rd_exp(1'b0, rows[i].exp);
		end
		// Odd command tags leave both selectors alone
		host_u.sel_reg(5'h00, 5'h10);
		host_u.put(1'b1, 8'h5c);
		host_u.put(1'b1, 8'h9f);
		rd_exp(1'b0, 8'h80);
		// Management-set byte leaves as a single pulse
		host_u.put(1'b1, 8'hfe);
		host_u.put(1'b0, 8'h96);
		#1;
		check8({7'h00, mgmt_set_stb_reg}, 8'h01);
		check8(mgmt_set_byte_reg, 8'h96);
		@(posedge core_clk);
		#1;
		check8({7'h00, mgmt_set_stb_reg}, 8'h00);
		// Management-get loaded from the far side
		@(posedge core_clk);
		mgmt_get_data <= 8'h3c;
		mgmt_get_load <= 1'b1;
		@(posedge core_clk);
		mgmt_get_load <= 1'b0;
		host_u.sel_reg(5'h00, 5'h1f);
		rd_exp(1'b0, 8'h3c);
		// Port counter: restart on reprogramming, wrap after byte 3
		@(posedge core_clk);
		stat_upd <= '{valid: 1'b1, port: 4'h0, idx: 4'h0,
			value: 32'h44332211};
		@(posedge core_clk);
		stat_upd.valid <= 1'b0;
		host_u.sel_reg(5'h10, 5'h00);
		rd_exp(1'b0, 8'h11);
		rd_exp(1'b0, 8'h22);
		host_u.put(1'b1, 8'he0);
		for (int i = 0; i < 5; i++) begin
			rd_exp(1'b0, 8'h11 * (8'(i % 4) + 8'h01));
		end
		// Repeater octets: later bytes come from the snapshot
		@(posedge core_clk);
		repeater_octets <= 32'hd4c3b2a1;
		host_u.sel_reg(5'h00, 5'h0c);
		rd_exp(1'b0, 8'ha1);
		@(posedge core_clk);
		repeater_octets <= 32'h00000000;
		rd_exp(1'b0, 8'hb2);
		rd_exp(1'b0, 8'hc3);
		rd_exp(1'b0, 8'hd4);
		// Transmit collisions, register 13, low byte first
		host_u.put(1'b1, 8'hed);
		for (int i = 0; i < 4; i++) begin
			rd_exp(1'b0, 8'h12 + 8'h22 * 8'(i));
		end
		// Six-byte values; a short write changes nothing
		for (int k = 0; k < 2; k++) begin
			wide = 48'h665544332211 + 48'(k);
			host_u.sel_reg(k == 0 ? 5'h00 : 5'h17, k == 0 ? 5'h0a : 5'h0e);
			host_u.put6(wide);
			for (int j = 0; j < 3; j++) begin
				host_u.put(1'b0, 8'hee);
			end
			host_u.put(1'b1, k == 0 ? 8'hea : 8'hee);
			for (int j = 0; j < 6; j++) begin
				rd_exp(1'b0, wide[8*j +: 8]);
			end
		end
		// Flag raises the interrupt, reading clears both
		@(posedge core_clk);
		flag_set[0] <= 8'h01;
		flag_set[8] <= 8'h02;
		@(posedge core_clk);
		flag_set[0] <= 8'h00;
		flag_set[8] <= 8'h00;
		repeat (2) @(posedge core_clk);
		#1;
		check8({7'h00, irq_reg}, 8'h01);
		rd_exp(1'b1, 8'ha0);
		host_u.sel_reg(5'h01, 5'h00);
		rd_exp(1'b0, 8'h01);
		rd_exp(1'b0, 8'h00);
		repeat (2) @(posedge core_clk);
		#1;
		check8({7'h00, irq_reg}, 8'h00);
		// Address-match flag stays until its own register is read
		host_u.sel_reg(5'h01, 5'h08);
		rd_exp(1'b0, 8'h02);
		rd_exp(1'b1, 8'h00);
		// Clock enable low freezes a configuration write
		host_u.sel_reg(5'h00, 5'h10);
		clk_en <= 1'b0;
		host_u.put(1'b0, 8'h11);
		clk_en <= 1'b1;
		rd_exp(1'b0, 8'h80);
		// Second reset keeps counters, clears configuration
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		host_u.sel_reg(5'h10, 5'h00);
		rd_exp(1'b0, 8'h11);
		host_u.sel_reg(5'h00, 5'h10);
		rd_exp(1'b0, 8'h00);
		complete_run();
	end
endmodule // tb_indirect_mgmt_register_map
